// File: src/sdc_socket_dma_ctrl.sv
// Control, mode and mask logic of a single-channel socket distributed DMA slave
// Summary of operation
// - Any write to the request register sets a software request; it starts transfers in block mode only.
// - Mode bits 7:6 select demand, single, block or reserved mode.
// - Mode bit 5 chooses address increment (0) or decrement (1).
// - Mode bit 4 enables auto-initialisation when set.
// - Mode bits 3:2 select none, memory write, memory read or reserved.
// - Mode bits 1:0 read as zero.
// - A master clear write resets the sequencer and the mode, mask, request, address, count and terminal count registers.
// - Mask bit 0 set ignores card requests; clear services them.
// - Card removal sets the mask bit automatically.
// - Mask bits 7:1 read as zero; only bit 0 works.
// - Request, mode, master clear and mask registers sit at 09h, 0Bh, 0Dh and 0Fh from the base.
// - Count drops by one per 8-bit transfer, two per 16-bit transfer.
// - Terminal count bits set at terminal count, clear on read or reset.
`timescale 1ns/1ps
module sdc_socket_dma_ctrl (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire sdc_pkg::sdc_bus_s bus_i,
  output logic [7:0] rdata_o,
  input wire logic card_dma_request_i,
  input wire logic card_present_i,
  input wire logic xfer_done_i,
  input wire logic wide_xfer_i,
  output logic service_req_o,
  output logic block_active_o,
  output logic [15:0] current_addr_o,
  output sdc_pkg::sdc_mode_s mode_o,
  output logic terminal_count_o
);
  import sdc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic req_sync;
  logic present_sync;

  sdc_sync2 u_req_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i(card_dma_request_i),
    .sync_o(req_sync)
  );

  sdc_sync2 u_present_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i(card_present_i),
    .sync_o(present_sync)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire wr_addr_lo = bus_i.wr && (bus_i.addr == SDC_OFF_ADDR);
  wire wr_addr_hi = bus_i.wr && (bus_i.addr == (SDC_OFF_ADDR + 4'h1));
  wire wr_cnt_lo = bus_i.wr && (bus_i.addr == SDC_OFF_COUNT);
  wire wr_cnt_hi = bus_i.wr && (bus_i.addr == (SDC_OFF_COUNT + 4'h1));
  wire wr_sw_req = bus_i.wr && (bus_i.addr == SDC_OFF_SW_REQ);
  wire wr_mode = bus_i.wr && (bus_i.addr == SDC_OFF_MODE);
  wire wr_clear = bus_i.wr && (bus_i.addr == SDC_OFF_CLEAR);
  wire wr_mask = bus_i.wr && (bus_i.addr == SDC_OFF_MASK);
  wire rd_status = bus_i.rd && (bus_i.addr == SDC_OFF_STATUS);

  // Master clear acts like the system reset for every register but present_d_ff, rdata_ff and the synchronisers
  wire soft_rst = sys_rst_i || wr_clear;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  sdc_mode_s mode_ff;
  logic mask_ff;
  logic sw_req_ff;
  logic tc_ff;
  logic present_d_ff;
  logic [15:0] base_addr_ff;
  logic [15:0] cur_addr_ff;
  logic [15:0] base_cnt_ff;
  logic [15:0] cur_cnt_ff;
  logic [7:0] rdata_ff;
  sdc_state_e state_ff;
  sdc_state_e nxt_state;

  wire card_removed = present_d_ff && !present_sync;
  wire block_mode = (mode_ff.transfer_mode_select == SDC_MODE_BLOCK);
  wire type_valid = (mode_ff.transfer_direction_type == SDC_TYPE_MEM_WRITE) ||
                    (mode_ff.transfer_direction_type == SDC_TYPE_MEM_READ);
  wire mode_valid = (mode_ff.transfer_mode_select != SDC_MODE_RSVD);
  wire card_req = req_sync && !mask_ff;
  // Software requests only count in block mode
  wire sw_req_ok = sw_req_ff && block_mode;
  wire start_req = (card_req || sw_req_ok) && type_valid && mode_valid;
  wire xfer_step = (state_ff == SDC_ST_XFER) && xfer_done_i;
  wire [15:0] cnt_step = wide_xfer_i ? SDC_COUNT_STEP16 : SDC_COUNT_STEP8;
  wire last_xfer = (cur_cnt_ff <= cnt_step);
  wire reach_tc = xfer_step && last_xfer;
  // Demand mode keeps going while the card holds its request
  wire keep_going = block_mode ||
                    ((mode_ff.transfer_mode_select == SDC_MODE_DEMAND) && card_req);
  wire [15:0] addr_next = mode_ff.address_direction ?
                          (cur_addr_ff - 16'h0001) : (cur_addr_ff + 16'h0001);

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SDC_ST_IDLE: begin
        if (start_req) begin
          nxt_state = SDC_ST_XFER;
        end
      end
      SDC_ST_XFER: begin
        if (reach_tc) begin
          nxt_state = SDC_ST_DONE;
        end else if (xfer_step && !keep_going) begin
          nxt_state = SDC_ST_IDLE;
        end
      end
      SDC_ST_DONE: begin
        nxt_state = SDC_ST_IDLE;
      end
      default: begin
        nxt_state = SDC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (soft_rst) begin
      state_ff <= SDC_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Mode, mask and software request
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (soft_rst) begin
      mode_ff <= sdc_mode_s'(SDC_MODE_RESET[SDC_MODE_SEL_HI:SDC_MODE_TYPE_LO]);
    end else if (wr_mode) begin
      mode_ff <= sdc_mode_s'(bus_i.wdata[SDC_MODE_SEL_HI:SDC_MODE_TYPE_LO]);
    end
  end

  always_ff @(posedge clock_i) begin
    if (soft_rst) begin
      mask_ff <= SDC_MASK_RESET;
    end else if (card_removed) begin
      mask_ff <= 1'b1;
    end else if (wr_mask) begin
      mask_ff <= bus_i.wdata[SDC_MASK_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (soft_rst) begin
      sw_req_ff <= 1'b0;
    end else if (wr_sw_req) begin
      sw_req_ff <= 1'b1;
    end else if (state_ff == SDC_ST_DONE) begin
      sw_req_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      present_d_ff <= 1'b0;
    end else begin
      present_d_ff <= present_sync;
    end
  end

  // ----------------------------------------------------------------
  // Address and count
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (soft_rst) begin
      base_addr_ff <= 16'h0000;
      cur_addr_ff <= 16'h0000;
    end else if (wr_addr_lo) begin
      base_addr_ff[7:0] <= bus_i.wdata;
      cur_addr_ff[7:0] <= bus_i.wdata;
    end else if (wr_addr_hi) begin
      base_addr_ff[15:8] <= bus_i.wdata;
      cur_addr_ff[15:8] <= bus_i.wdata;
    end else if (reach_tc && mode_ff.auto_reload_enable) begin
      cur_addr_ff <= base_addr_ff;
    end else if (xfer_step) begin
      cur_addr_ff <= addr_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (soft_rst) begin
      base_cnt_ff <= 16'h0000;
      cur_cnt_ff <= 16'h0000;
    end else if (wr_cnt_lo) begin
      base_cnt_ff[7:0] <= bus_i.wdata;
      cur_cnt_ff[7:0] <= bus_i.wdata;
    end else if (wr_cnt_hi) begin
      base_cnt_ff[15:8] <= bus_i.wdata;
      cur_cnt_ff[15:8] <= bus_i.wdata;
    end else if (reach_tc && mode_ff.auto_reload_enable) begin
      cur_cnt_ff <= base_cnt_ff;
    end else if (reach_tc) begin
      cur_cnt_ff <= 16'h0000;
    end else if (xfer_step) begin
      cur_cnt_ff <= cur_cnt_ff - cnt_step;
    end
  end

  // ----------------------------------------------------------------
  // Terminal count status, set wins over read clear
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (soft_rst) begin
      tc_ff <= 1'b0;
    end else if (reach_tc) begin
      tc_ff <= 1'b1;
    end else if (rd_status) begin
      tc_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (bus_i.addr)
      SDC_OFF_ADDR: rd_mux = cur_addr_ff[7:0];
      4'h1: rd_mux = cur_addr_ff[15:8];
      SDC_OFF_COUNT: rd_mux = cur_cnt_ff[7:0];
      4'h5: rd_mux = cur_cnt_ff[15:8];
      SDC_OFF_STATUS: rd_mux = {{4{req_sync}}, {4{tc_ff}}};
      SDC_OFF_MODE: rd_mux = {mode_ff, 2'b00};
      SDC_OFF_MASK: rd_mux = {7'h00, mask_ff};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_ff <= 8'h00;
    end else if (bus_i.rd) begin
      rdata_ff <= rd_mux;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = rdata_ff;
  assign service_req_o = (state_ff == SDC_ST_XFER);
  assign block_active_o = (state_ff == SDC_ST_XFER) && block_mode;
  assign current_addr_o = cur_addr_ff;
  assign mode_o = mode_ff;
  assign terminal_count_o = tc_ff;
endmodule

// File: src/sdc_pkg.sv
// Package with register map, field layout and types of the socket DMA slave control block
package sdc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] SDC_OFF_ADDR = 4'h0;
  localparam logic [3:0] SDC_OFF_COUNT = 4'h4;
  localparam logic [3:0] SDC_OFF_STATUS = 4'h8;
  localparam logic [3:0] SDC_OFF_SW_REQ = 4'h9;
  localparam logic [3:0] SDC_OFF_MODE = 4'hB;
  localparam logic [3:0] SDC_OFF_CLEAR = 4'hD;
  localparam logic [3:0] SDC_OFF_MASK = 4'hF;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int SDC_MODE_SEL_HI = 7;
  localparam int SDC_MODE_SEL_LO = 6;
  localparam int SDC_MODE_DIR_BIT = 5;
  localparam int SDC_MODE_AUTO_BIT = 4;
  localparam int SDC_MODE_TYPE_HI = 3;
  localparam int SDC_MODE_TYPE_LO = 2;
  localparam int SDC_MASK_BIT = 0;
  localparam int SDC_STAT_REQ_LO = 4;
  localparam logic [7:0] SDC_MODE_RESET = 8'h00;
  localparam logic SDC_MASK_RESET = 1'b1;
  localparam logic [15:0] SDC_COUNT_STEP8 = 16'h0001;
  localparam logic [15:0] SDC_COUNT_STEP16 = 16'h0002;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SDC_MODE_DEMAND = 2'b00,
    SDC_MODE_SINGLE = 2'b01,
    SDC_MODE_BLOCK = 2'b10,
    SDC_MODE_RSVD = 2'b11
  } sdc_xfer_mode_e;

  typedef enum logic [1:0] {
    SDC_TYPE_NONE = 2'b00,
    SDC_TYPE_MEM_WRITE = 2'b01,
    SDC_TYPE_MEM_READ = 2'b10,
    SDC_TYPE_RSVD = 2'b11
  } sdc_xfer_type_e;

  typedef enum logic [1:0] {
    SDC_ST_IDLE = 2'b00,
    SDC_ST_XFER = 2'b01,
    SDC_ST_DONE = 2'b10
  } sdc_state_e;

  typedef struct packed {
    sdc_xfer_mode_e transfer_mode_select;
    logic address_direction;
    logic auto_reload_enable;
    sdc_xfer_type_e transfer_direction_type;
  } sdc_mode_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sdc_bus_s;

endpackage

// File: src/sdc_sync2.sv
// Two flip-flop synchroniser for one pin-level signal
`timescale 1ns/1ps
module sdc_sync2 (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule

// File: testbench/sdc_ctrl_checker.sv
// Port checker of the socket DMA slave control block
`timescale 1ns/1ps
module sdc_ctrl_checker (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire sdc_pkg::sdc_bus_s bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic xfer_done_i,
  input wire logic service_req_o,
  input wire logic block_active_o,
  input wire logic [15:0] current_addr_o,
  input wire sdc_pkg::sdc_mode_s mode_o,
  input wire logic terminal_count_o
);
  import sdc_pkg::*;
  // ------------------------------
  // Port relations
  // ------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  AST_RD_IDLE: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  AST_MODE_WR: assert property (bus_i.wr && bus_i.addr == SDC_OFF_MODE
    |=> mode_o == $past(bus_i.wdata[7:2])) else $error("mode not loaded");
  AST_MODE_RD: assert property ($past(bus_i.rd) && $past(bus_i.addr) == SDC_OFF_MODE
    |-> rdata_o == {$past(mode_o), 2'h0}) else $error("mode readback wrong");
  AST_MASK_RD: assert property ($past(bus_i.rd) && $past(bus_i.addr) == SDC_OFF_MASK
    |-> rdata_o[7:1] == 7'h00) else $error("mask upper bits not zero");
  AST_CLEAR: assert property (bus_i.wr && bus_i.addr == SDC_OFF_CLEAR
    |=> mode_o == 6'h00 && !service_req_o && !terminal_count_o) else $error("clear failed");
  AST_BLOCK: assert property (block_active_o
    |-> service_req_o && mode_o.transfer_mode_select == SDC_MODE_BLOCK) else $error("block flag");
  AST_ADDR: assert property (service_req_o && xfer_done_i |=> $rose(terminal_count_o)
    || current_addr_o == $past(current_addr_o) + ($past(mode_o.address_direction)
    ? 16'hFFFF : 16'h0001)) else $error("address step wrong");
  AST_TC_RD: assert property (bus_i.rd && bus_i.addr == SDC_OFF_STATUS && !xfer_done_i
    |=> !terminal_count_o && rdata_o[3:0] == {4{$past(terminal_count_o)}})
    else $error("terminal count read wrong");
  AST_TC_END: assert property ($rose(terminal_count_o) |-> ##[0:2] !service_req_o)
    else $error("service outlives terminal count");
endmodule

// File: testbench/sdc_card_model.sv
// Behavioural card in the socket: presence, request line, transfer pulses
`timescale 1ns/1ps
module sdc_card_model (
  input wire logic clock_i,
  input wire logic plug_i,
  input wire logic want_i,
  input wire logic [1:0] gap_i,
  input wire logic serving_i,
  output logic present_o,
  output logic card_dma_request_o,
  output logic done_o
);
  logic [1:0] wait_ff;
  // ------------------------------
  // Pins and transfer pacing
  // ------------------------------
  assign present_o = plug_i;
  // Removed card leaves the pulled-down request line low
  assign card_dma_request_o = plug_i & want_i;
  always_ff @(posedge clock_i) begin
    wait_ff <= (serving_i && !done_o && wait_ff != gap_i) ? wait_ff + 2'h1 : 2'h0;
    done_o <= serving_i && !done_o && wait_ff == gap_i;
  end
endmodule

// File: testbench/socket_dma_slave_control_tb_top.sv
// Testbench top of the socket DMA slave control block
`timescale 1ns/1ps
module socket_dma_slave_control_tb_top;
  import sdc_pkg::*;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  sdc_bus_s bus = '0;
  logic plug = 1'b1;
  logic want = 1'b0;
  logic wide = 1'b0;
  logic [1:0] gap = 2'h0;
  logic [7:0] rdata;
  logic card_dma_request, present, done, serv, blk, tc;
  logic [15:0] addr;
  sdc_mode_s mode;
  int n_mismatch = 0;
  int check_count = 0;
  int pulses = 0;
  always #20 clock_i = ~clock_i;
  sdc_socket_dma_ctrl i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus_i(bus),
    .rdata_o(rdata), .card_dma_request_i(card_dma_request), .card_present_i(present),
    .xfer_done_i(done), .wide_xfer_i(wide), .service_req_o(serv),
    .block_active_o(blk), .current_addr_o(addr), .mode_o(mode), .terminal_count_o(tc));
  sdc_card_model i_card (.clock_i(clock_i), .plug_i(plug), .want_i(want), .gap_i(gap),
    .serving_i(serv), .present_o(present), .card_dma_request_o(card_dma_request), .done_o(done));
  always @(posedge clock_i) if (done && serv) pulses++;
  // ------------------------------
  // Access tasks
  // ------------------------------
  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One strobe cycle, then one idle cycle so the next call starts on a fresh edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus <= '0;
    @(posedge clock_i);
  endtask
  // Read data stand in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus <= '0;
    #1 chk(rdata, e);
    @(posedge clock_i);
  endtask
  // Polls the level settled in the cycle before each edge
  task automatic wait_serv(input logic v);
    int i;
    for (i = 0; i < 300 && serv !== v; i++) @(posedge clock_i);
    if (serv !== v) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic block_run(input logic [7:0] md, input logic w, input logic [7:0] cnt,
                           input int n, input logic [15:0] a_exp);
    wr(SDC_OFF_ADDR, 8'h34);
    wr(4'h1, 8'h12);
    wr(SDC_OFF_COUNT, cnt);
    wr(4'h5, 8'h00);
    wr(SDC_OFF_MODE, md);
    wide <= w;
    pulses = 0;
    wr(SDC_OFF_SW_REQ, 8'h5A);
    wait_serv(1'b1);
    chk(blk, 1'b1);
    wait_serv(1'b0);
    chk(pulses, n);
    chk(addr, a_exp);
    rd(SDC_OFF_STATUS, 8'h0F);
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    rd(SDC_OFF_MODE, 8'h00);
    rd(SDC_OFF_MASK, 8'h01);
    rd(4'h3, 8'h00);
    for (int i = 0; i < 64; i++) begin
      wr(SDC_OFF_MODE, {i[5:0], 2'h3});
      rd(SDC_OFF_MODE, {i[5:0], 2'h0});
      chk(mode, i[5:0]);
    end
    wr(SDC_OFF_MASK, 8'hFF);
    rd(SDC_OFF_MASK, 8'h01);
    wr(SDC_OFF_MODE, 8'h04);
    want <= 1'b1;
    repeat (10) @(posedge clock_i);
    chk(serv, 1'b0);
    wr(SDC_OFF_MASK, 8'h00);
    wait_serv(1'b1);
    want <= 1'b0;
    wait_serv(1'b0);
    repeat (4) @(posedge clock_i);
    rd(SDC_OFF_STATUS, 8'h0F);
    rd(SDC_OFF_STATUS, 8'h00);
    // Single mode drops service after one transfer, long before terminal count
    wr(SDC_OFF_COUNT, 8'h10);
    wr(SDC_OFF_MODE, 8'h44);
    want <= 1'b1;
    wait_serv(1'b1);
    wait_serv(1'b0);
    chk(tc, 1'b0);
    want <= 1'b0;
    repeat (8) @(posedge clock_i);
    chk(serv, 1'b0);
    block_run(8'hA4, 1'b0, 8'h03, 3, 16'h1231);
    gap <= 2'h3;
    block_run(8'h88, 1'b1, 8'h04, 2, 16'h1236);
    // Auto-initialisation reloads address and count at terminal count
    block_run(8'h94, 1'b0, 8'h02, 2, 16'h1234);
    rd(SDC_OFF_COUNT, 8'h02);
    plug <= 1'b0;
    repeat (6) @(posedge clock_i);
    rd(SDC_OFF_MASK, 8'h01);
    plug <= 1'b1;
    wr(SDC_OFF_MASK, 8'h00);
    wr(SDC_OFF_MODE, 8'hA4);
    wr(SDC_OFF_CLEAR, 8'h5A);
    rd(SDC_OFF_MODE, 8'h00);
    rd(SDC_OFF_MASK, 8'h01);
    chk(addr, 16'h0000);
    final_report();
  end
endmodule
bind sdc_socket_dma_ctrl sdc_ctrl_checker i_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .xfer_done_i(xfer_done_i), .service_req_o(service_req_o),
  .block_active_o(block_active_o), .current_addr_o(current_addr_o), .mode_o(mode_o),
  .terminal_count_o(terminal_count_o));
